// ---- display_serial_regs.svh ----
`ifndef DISPLAY_SERIAL_REGS_SVH
`define DISPLAY_SERIAL_REGS_SVH

// ****************************************************************************
// Command word layout
// ****************************************************************************

// Number of bits in one serial command word.
`define CMD_WORD_BITS 16
// Position of the most significant address bit.
`define CMD_ADDR_MSB 11
// Position of the least significant address bit.
`define CMD_ADDR_LSB 8
// Position of the most significant data bit.
`define CMD_DATA_MSB 7
// Position of the least significant data bit.
`define CMD_DATA_LSB 0
// Reset value of the shift and hold word registers.
`define CMD_WORD_RESET 16'h0000

// ****************************************************************************
// Drivers and buffering
// ****************************************************************************

// Number of digit drive lines.
`define DIGIT_LINES 8
// Number of segment drive lines, the decimal point being the last.
`define SEGMENT_LINES 8
// Depth of the command FIFO between the link and the register bank.
`define CMD_FIFO_DEPTH 8

// ****************************************************************************
// Timing
// ****************************************************************************

// System clock period in nanoseconds.
`define SYS_CLK_PERIOD_NS 50
// Least serial clock period in nanoseconds.
`define SERIAL_CLK_MIN_PERIOD_NS 100

`endif

// ---- display_serial_pkg.sv ----
// ****************************************************************************
// Types shared by the serial load port
// ****************************************************************************

package display_serial_pkg;

    // One latched command word split into its fields.
    typedef struct packed {
        logic [3:0] spare;
        logic [3:0] addr;
        logic [7:0] data;
    } cmd_word_s;

    // State of the word waiting to enter the FIFO.
    typedef enum logic [0:0] {
        PUSH_IDLE = 1'b0,
        PUSH_WAIT = 1'b1
    } push_state_e;

endpackage

// ---- cmd_fifo.sv ----
`timescale 1ns/100ps

// ****************************************************************************
// Synchronous FIFO with valid and ready on both sides
// ****************************************************************************

module cmd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic s_valid_in,
    output logic s_ready_out,
    input wire logic [WIDTH-1:0] s_data_in,
    output logic m_valid_out,
    input wire logic m_ready_in,
    output logic [WIDTH-1:0] m_data_out
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Storage array for the queued words.
    logic [WIDTH-1:0] mem_r [DEPTH];
    // Write and read pointers.
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    // Number of words held.
    logic [PW:0] count_r;

    // Handshake decode.
    wire push_w = s_valid_in && s_ready_out;
    wire pop_w = m_valid_out && m_ready_in;
    wire wr_wrap_w = (wr_ptr_r == PW'(DEPTH - 1));
    wire rd_wrap_w = (rd_ptr_r == PW'(DEPTH - 1));

    // Full and empty come straight from the count.
    assign s_ready_out = (count_r != (PW + 1)'(DEPTH));
    assign m_valid_out = (count_r != '0);
    assign m_data_out = mem_r[rd_ptr_r];

    // The array is written on every accepted push.
    always_ff @(posedge clk_in) begin
        if (push_w) begin
            mem_r[wr_ptr_r] <= s_data_in;
        end
    end

    // Pointers and count move with the handshakes.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push_w) begin
                wr_ptr_r <= wr_wrap_w ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop_w) begin
                rd_ptr_r <= rd_wrap_w ? '0 : rd_ptr_r + 1'b1;
            end
            if (push_w && !pop_w) begin
                count_r <= count_r + 1'b1;
            end else if (pop_w && !push_w) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

// ---- display_serial_load_port.sv ----
// Overview of operation
// - Shift serial input on each rising clock.
// - Load strobe rise latches last sixteen bits.
// - Select low gates shifting; rise latches word.
// - Select high ignores clock for in and out.
// - Output updates on falling clock edges.
// - Input reaches output sixteen and half clocks later.
// - Serial output is always actively driven.
// - Strobe variant: off digit driven high.
// - Select variant: off digit floats.
// - Strobe variant: off segment driven low.
// - Select variant: off segment floats.
// - Address bits eleven to eight, data seven to zero.

`timescale 1ns/100ps

`include "display_serial_regs.svh"

module display_serial_load_port #(
    parameter bit SELECT_GATED = 1'b0,
    parameter int FIFO_DEPTH = `CMD_FIFO_DEPTH
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic serial_clk_in,
    input wire logic serial_data_in,
    input wire logic load_in,
    input wire logic cs_n_in,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    input wire logic bank_ready_in,
    output logic bank_wr_out,
    output logic [3:0] bank_addr_out,
    output logic [7:0] bank_data_out,
    output logic overrun_out,
    input wire logic [`DIGIT_LINES-1:0] digit_on_in,
    input wire logic [`SEGMENT_LINES-1:0] segment_on_in,
    output logic [`DIGIT_LINES-1:0] digit_sink_lines_out,
    output logic [`DIGIT_LINES-1:0] digit_sink_lines_oe_out,
    output logic [`SEGMENT_LINES-2:0] segment_source_lines_out,
    output logic [`SEGMENT_LINES-2:0] segment_source_lines_oe_out,
    output logic decimal_point_line_out,
    output logic decimal_point_line_oe_out
);

    // ************************************************************************
    // Link domain: shifting and serial output
    // ************************************************************************

    // Shift register filled from the serial input.
    logic [`CMD_WORD_BITS-1:0] shift_r;
    // Extra stage that holds the bit leaving the shift register.
    logic spill_r;
    // Serial output flop, updated on the falling edge.
    logic dout_r;
    // Word latched by the strobe edge.
    logic [`CMD_WORD_BITS-1:0] latch_word_r;
    // Toggle that marks each latch event.
    logic latch_tog_r;

    // In the gated variant the clock only counts while select is low.
    wire shift_en_w = SELECT_GATED ? !cs_n_in : 1'b1;
    // The latch edge comes from the select pin or the load pin.
    wire strobe_w = SELECT_GATED ? cs_n_in : load_in;

    // Rising edges shift the input in; the first bit sent ends up on top.
    // The reset is asynchronous here because the link clock may stand still.
    always_ff @(posedge serial_clk_in or posedge srst_in) begin
        if (srst_in) begin
            shift_r <= `CMD_WORD_RESET;
            spill_r <= 1'b0;
        end else if (shift_en_w) begin
            shift_r <= {shift_r[`CMD_WORD_BITS-2:0], serial_data_in};
            spill_r <= shift_r[`CMD_WORD_BITS-1];
        end
    end

    // Falling edges present the bit that has left the register.
    // The spill stage adds the sixteenth cycle, giving sixteen and a half.
    always_ff @(negedge serial_clk_in or posedge srst_in) begin
        if (srst_in) begin
            dout_r <= 1'b0;
        end else if (shift_en_w) begin
            dout_r <= spill_r;
        end
    end

    // The strobe rising edge captures the last sixteen shifted bits.
    // The host raises it after the sixteenth edge and before the next.
    always_ff @(posedge strobe_w) begin
        latch_word_r <= shift_r;
    end

    // A toggle per latch lets the system domain see each event once.
    always_ff @(posedge strobe_w or posedge srst_in) begin
        if (srst_in) begin
            latch_tog_r <= 1'b0;
        end else begin
            latch_tog_r <= !latch_tog_r;
        end
    end

    // The output is driven at all times, in both variants.
    assign serial_data_out = dout_r;
    assign serial_data_oe_out = 1'b1;

    // ************************************************************************
    // Crossing into the system domain
    // ************************************************************************

    // Two-flop synchroniser for the latch toggle.
    logic tog_s1_r;
    logic tog_s2_r;
    // Last toggle level already handled.
    logic tog_seen_r;

    // First stage feeds only the second stage.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
        end else begin
            tog_s1_r <= latch_tog_r;
            tog_s2_r <= tog_s1_r;
        end
    end

    // A new latch event shows as a change of the synchronised toggle.
    wire latch_evt_w = (tog_s2_r != tog_seen_r);

    // Remember the handled level so each event fires exactly once.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            tog_seen_r <= 1'b0;
        end else begin
            tog_seen_r <= tog_s2_r;
        end
    end

    // ************************************************************************
    // Pushing latched words into the FIFO
    // ************************************************************************

    // Word waiting to enter the FIFO.
    display_serial_pkg::cmd_word_s hold_r;
    display_serial_pkg::cmd_word_s hold_nxt;
    // Push state: idle or holding a word.
    display_serial_pkg::push_state_e push_state_r;
    display_serial_pkg::push_state_e push_state_nxt;
    // Sticky flag for a word dropped because the FIFO stayed full.
    logic overrun_r;
    logic overrun_nxt;
    // FIFO handshake on the filling side.
    logic fifo_s_ready;
    // FIFO handshake on the draining side.
    logic fifo_m_valid;
    logic [`CMD_WORD_BITS-1:0] fifo_m_data;

    // A word is offered while one is held.
    wire fifo_s_valid_w = (push_state_r == display_serial_pkg::PUSH_WAIT);
    wire push_done_w = fifo_s_valid_w && fifo_s_ready;
    // The latched word is stable long after its toggle has crossed.
    wire display_serial_pkg::cmd_word_s new_word_w = latch_word_r;

    // Next state of the push stage; a full FIFO stalls it.
    always_comb begin
        hold_nxt = hold_r;
        push_state_nxt = push_state_r;
        overrun_nxt = overrun_r;
        case (push_state_r)
            display_serial_pkg::PUSH_IDLE: begin
                // Take a new word when one arrives.
                if (latch_evt_w) begin
                    hold_nxt = new_word_w;
                    push_state_nxt = display_serial_pkg::PUSH_WAIT;
                end
            end
            display_serial_pkg::PUSH_WAIT: begin
                // Replace the word as it leaves, or drop the newcomer.
                if (latch_evt_w && push_done_w) begin
                    hold_nxt = new_word_w;
                end else if (latch_evt_w) begin
                    overrun_nxt = 1'b1;
                end else if (push_done_w) begin
                    push_state_nxt = display_serial_pkg::PUSH_IDLE;
                end
            end
            default: begin
                push_state_nxt = display_serial_pkg::PUSH_IDLE;
            end
        endcase
    end

    // Registers of the push stage.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            hold_r <= `CMD_WORD_RESET;
            push_state_r <= display_serial_pkg::PUSH_IDLE;
            overrun_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
            push_state_r <= push_state_nxt;
            overrun_r <= overrun_nxt;
        end
    end

    assign overrun_out = overrun_r;

    // Eight-word queue between the link and the register bank.
    cmd_fifo #(
        .WIDTH(`CMD_WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk_in(sys_clk_in),
        .srst_in(srst_in),
        .s_valid_in(fifo_s_valid_w),
        .s_ready_out(fifo_s_ready),
        .s_data_in(hold_r),
        .m_valid_out(fifo_m_valid),
        .m_ready_in(bank_ready_in),
        .m_data_out(fifo_m_data)
    );

    // ************************************************************************
    // Register bank write port
    // ************************************************************************

    // One-cycle write pulse with its address and data.
    logic bank_wr_r;
    logic [3:0] bank_addr_r;
    logic [7:0] bank_data_r;

    // A word leaves the FIFO when the bank is ready for it.
    wire bank_take_w = fifo_m_valid && bank_ready_in;
    // Field split: the top four bits are ignored.
    wire [3:0] word_addr_w = fifo_m_data[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
    wire [7:0] word_data_w = fifo_m_data[`CMD_DATA_MSB:`CMD_DATA_LSB];

    // Each word taken gives exactly one pulse; fields hold afterwards.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            bank_wr_r <= 1'b0;
            bank_addr_r <= 4'h0;
            bank_data_r <= 8'h00;
        end else begin
            bank_wr_r <= bank_take_w;
            if (bank_take_w) begin
                bank_addr_r <= word_addr_w;
                bank_data_r <= word_data_w;
            end
        end
    end

    assign bank_wr_out = bank_wr_r;
    assign bank_addr_out = bank_addr_r;
    assign bank_data_out = bank_data_r;

    // ************************************************************************
    // Digit and segment drivers
    // ************************************************************************

    // Registered pin levels and enables.
    logic [`DIGIT_LINES-1:0] dig_lvl_r;
    logic [`DIGIT_LINES-1:0] dig_oe_r;
    logic [`SEGMENT_LINES-1:0] seg_lvl_r;
    logic [`SEGMENT_LINES-1:0] seg_oe_r;

    genvar gi;
    generate
        for (gi = 0; gi < `DIGIT_LINES; gi++) begin : g_digit
            // An on digit sinks; an off digit pulls high or floats.
            always_ff @(posedge sys_clk_in) begin
                if (srst_in) begin
                    dig_lvl_r[gi] <= 1'b1;
                    dig_oe_r[gi] <= !SELECT_GATED;
                end else begin
                    dig_lvl_r[gi] <= !digit_on_in[gi];
                    dig_oe_r[gi] <= digit_on_in[gi] || !SELECT_GATED;
                end
            end
        end
        for (gi = 0; gi < `SEGMENT_LINES; gi++) begin : g_segment
            // An on segment sources; an off segment pulls low or floats.
            always_ff @(posedge sys_clk_in) begin
                if (srst_in) begin
                    seg_lvl_r[gi] <= 1'b0;
                    seg_oe_r[gi] <= !SELECT_GATED;
                end else begin
                    seg_lvl_r[gi] <= segment_on_in[gi];
                    seg_oe_r[gi] <= segment_on_in[gi] || !SELECT_GATED;
                end
            end
        end
    endgenerate

    // The top segment bit is the decimal point.
    assign digit_sink_lines_out = dig_lvl_r;
    assign digit_sink_lines_oe_out = dig_oe_r;
    assign segment_source_lines_out = seg_lvl_r[`SEGMENT_LINES-2:0];
    assign segment_source_lines_oe_out = seg_oe_r[`SEGMENT_LINES-2:0];
    assign decimal_point_line_out = seg_lvl_r[`SEGMENT_LINES-1];
    assign decimal_point_line_oe_out = seg_oe_r[`SEGMENT_LINES-1];

endmodule

// ---- display_serial_load_port_chk.sv ----
`timescale 1ns/100ps
`include "display_serial_regs.svh"

// ********
// Port checker for the serial load port
// ********

module display_serial_load_port_chk #(
    parameter bit SELECT_GATED = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic serial_clk_in,
    input wire logic serial_data_in,
    input wire logic load_in,
    input wire logic cs_n_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_out,
    input wire logic bank_ready_in,
    input wire logic bank_wr_out,
    input wire logic [3:0] bank_addr_out,
    input wire logic [7:0] bank_data_out,
    input wire logic overrun_out,
    input wire logic [`DIGIT_LINES-1:0] digit_on_in,
    input wire logic [`SEGMENT_LINES-1:0] segment_on_in,
    input wire logic [`DIGIT_LINES-1:0] digit_sink_lines_out,
    input wire logic [`DIGIT_LINES-1:0] digit_sink_lines_oe_out,
    input wire logic [`SEGMENT_LINES-2:0] segment_source_lines_out,
    input wire logic [`SEGMENT_LINES-2:0] segment_source_lines_oe_out,
    input wire logic decimal_point_line_out,
    input wire logic decimal_point_line_oe_out
);
    // Strobe that ends a frame in the chosen variant.
    wire logic latch_w = SELECT_GATED ? cs_n_in : load_in;
    // Serial rising edges since reset, held at 17 so early zeros are skipped.
    logic [4:0] rise_cnt_r;

    // Counts link edges; the link clock may stop, so reset acts at once.
    always_ff @(posedge serial_clk_in or posedge srst_in) begin
        if (srst_in) begin
            rise_cnt_r <= 5'h00;
        end else if (rise_cnt_r != 5'h11) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
        end
    end

    // ********
    // Assertions
    // ********

    a_dout_enabled: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        serial_data_oe_out == 1'b1) else $error("Chain output was released.");
    a_write_after_ready: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        bank_wr_out |-> $past(bank_ready_in)) else $error("Write pulse without ready.");
    a_fields_hold: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !bank_wr_out && !$past(srst_in) |-> $stable({bank_addr_out, bank_data_out}))
        else $error("Bank fields moved without a write pulse.");
    a_digit_off_drive: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !$past(srst_in) |-> digit_sink_lines_out == ~$past(digit_on_in)
        && digit_sink_lines_oe_out == (SELECT_GATED ? $past(digit_on_in) : 8'hFF))
        else $error("Digit drive wrong for its on state.");
    a_segment_off_drive: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !$past(srst_in) |-> segment_source_lines_out == $past(segment_on_in[6:0])
        && segment_source_lines_oe_out == (SELECT_GATED ? $past(segment_on_in[6:0]) : 7'h7F))
        else $error("Segment drive wrong for its on state.");
    a_point_off_drive: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !$past(srst_in) |-> decimal_point_line_out == $past(segment_on_in[7])
        && decimal_point_line_oe_out == (SELECT_GATED ? $past(segment_on_in[7]) : 1'b1))
        else $error("Decimal point drive wrong for its on state.");
    a_latch_to_write: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        $rose(latch_w) && bank_ready_in |-> ##[1:8] bank_wr_out)
        else $error("Latched word never reached the bank.");
    a_reset_quiet: assert property (@(posedge sys_clk_in)
        srst_in |=> !bank_wr_out && !overrun_out && serial_data_out == 1'b0)
        else $error("Outputs not quiet after reset.");
    a_chain_delay: assert property (@(posedge serial_clk_in) disable iff (srst_in)
        rise_cnt_r == 5'h11 && !SELECT_GATED |-> serial_data_out == $past(serial_data_in, 17))
        else $error("Chain output differs from input seventeen rises back.");

    c_overrun: cover property (@(posedge sys_clk_in) disable iff (srst_in) $rose(overrun_out));
    c_back_to_back: cover property (@(posedge sys_clk_in) disable iff (srst_in)
        bank_wr_out ##1 bank_wr_out);
    c_latch: cover property (@(posedge sys_clk_in) disable iff (srst_in)
        $rose(latch_w) && bank_ready_in);
endmodule

// ---- display_host_model.sv ----
`timescale 1ns/100ps

// ********
// Host that shifts words into the link
// ********

module display_host_model (
    input wire logic dout_in,
    output logic sclk_out,
    output logic sdata_out,
    output logic load_out
);
    // Chain output bits seen during the last frame, oldest first.
    logic [15:0] echo_r;

    // Link is idle with the clock standing low.
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        load_out = 1'b0;
        echo_r = 16'h0000;
    end

    // Sends one word at a 160 ns bit time; the strobe rises after the last rise.
    task automatic send(input logic [15:0] w, input logic latch);
        for (int i = 15; i >= 0; i--) begin
            sdata_out = w[i];
            #40 sclk_out = 1'b1;
            #40 load_out = latch && i == 0;
            #40 sclk_out = 1'b0;
            #20 echo_r = {echo_r[14:0], dout_in};
            #20;
        end
        // A line whose hold has run out shows the inverse, not the last bit.
        sdata_out = ~w[0];
        #40 load_out = 1'b0;
    endtask
endmodule

// ---- tb_display_serial_load_port.sv ----
`timescale 1ns/100ps
`include "display_serial_regs.svh"

`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end

module tb_display_serial_load_port;
    // One ordinary case: word sent, driver inputs, and what should come out.
    typedef struct {
        display_serial_pkg::cmd_word_s word;
        logic [7:0] dig_on;
        logic [7:0] seg_on;
        logic [11:0] exp_cmd;
        logic [7:0] exp_dig;
        logic [7:0] exp_seg;
    } row_s;

    row_s rows[4] = '{'{16'hF1A5, 8'h01, 8'h80, 12'h1A5, 8'hFE, 8'h80},
        '{16'h0C01, 8'hA5, 8'h7F, 12'hC01, 8'h5A, 8'h7F},
        '{16'h5F00, 8'hFF, 8'h00, 12'hF00, 8'h00, 8'h00},
        '{16'hA9FF, 8'h00, 8'hFF, 12'h9FF, 8'hFF, 8'hFF}};
    logic clk, srst, sclk, sdin, load, cs_n, dout, dout_oe, rdy, wr, ovr, dp_lv, dp_oe;
    logic wr2, ovr2, dout2; // Outputs of the select-gated copy.
    logic [3:0] addr, addr2;
    logic [7:0] data, data2, dig_on, seg_on, dig_lv, dig_oe;
    logic [6:0] seg_lv, seg_oe;
    logic [11:0] got_q[$]; // Words written to the bank, in arrival order.
    logic [11:0] got2_q[$]; // Words written by the select-gated copy.
    logic [11:0] w;
    logic [15:0] prev;
    int errors = 0;
    int num_checks = 0;

    display_serial_load_port dut (.sys_clk_in(clk), .srst_in(srst), .serial_clk_in(sclk),
        .serial_data_in(sdin), .load_in(load), .cs_n_in(cs_n), .serial_data_out(dout),
        .serial_data_oe_out(dout_oe), .bank_ready_in(rdy), .bank_wr_out(wr),
        .bank_addr_out(addr), .bank_data_out(data), .overrun_out(ovr),
        .digit_on_in(dig_on), .segment_on_in(seg_on), .digit_sink_lines_out(dig_lv),
        .digit_sink_lines_oe_out(dig_oe), .segment_source_lines_out(seg_lv),
        .segment_source_lines_oe_out(seg_oe), .decimal_point_line_out(dp_lv),
        .decimal_point_line_oe_out(dp_oe));
    // Select-gated copy on the same link; it shifts only while cs_n is low.
    display_serial_load_port #(.SELECT_GATED(1'b1)) dut_sel (.sys_clk_in(clk), .srst_in(srst),
        .serial_clk_in(sclk), .serial_data_in(sdin), .load_in(load), .cs_n_in(cs_n),
        .serial_data_out(dout2), .serial_data_oe_out(), .bank_ready_in(rdy), .bank_wr_out(wr2),
        .bank_addr_out(addr2), .bank_data_out(data2), .overrun_out(ovr2), .digit_on_in(dig_on),
        .segment_on_in(seg_on), .digit_sink_lines_out(), .digit_sink_lines_oe_out(),
        .segment_source_lines_out(), .segment_source_lines_oe_out(),
        .decimal_point_line_out(), .decimal_point_line_oe_out());
    display_host_model host (.dout_in(dout), .sclk_out(sclk), .sdata_out(sdin),
        .load_out(load));

    // System clock, 50 ns period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Collects every word the blocks hand to the bank, sampled once settled.
    always @(negedge clk) begin
        if (wr === 1'b1) begin
            got_q.push_back({addr, data});
        end
        if (wr2 === 1'b1) begin
            got2_q.push_back({addr2, data2});
        end
    end

    // Frames one word; select is low only for words meant to be latched.
    task automatic send_word(input logic [15:0] wd, input logic latch);
        cs_n = !latch;
        host.send(wd, latch);
        cs_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    // Waits, bounded, until n words have arrived.
    task automatic wait_words(input int n);
        for (int k = 0; k < 400 && (got_q.size() < n || got2_q.size() < n); k++) begin
            @(negedge clk);
        end
    endtask

    // Values the chain output and enable, write, overrun and digit and segment levels must show while reset is held.
    task automatic check_reset_values();
        `CHECK(dout, 1'b0)
        `CHECK(dout_oe, 1'b1)
        `CHECK(wr, 1'b0)
        `CHECK(ovr, 1'b0)
        `CHECK(dig_lv, 8'hFF)
        `CHECK(seg_lv, 7'h00)
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Some twenty frames of about 2.7 us each; this limit leaves ample room.
    initial begin
        #300000;
        errors++;
        summarize();
    end

    // ********
    // Main sequence
    // ********
    initial begin
        srst = 1'b1;
        cs_n = 1'b1;
        rdy = 1'b1;
        dig_on = 8'h00;
        seg_on = 8'h00;
        prev = 16'h0000;
        repeat (20) @(negedge clk);
        check_reset_values();
        srst = 1'b0;
        $display("reset test done");
        // Ordinary cases: word, fields, driver pins and chain echo.
        for (int r = 0; r < 4; r++) begin
            @(negedge clk);
            dig_on = rows[r].dig_on;
            seg_on = rows[r].seg_on;
            send_word(rows[r].word, 1'b1);
            wait_words(1);
            w = got_q.pop_front();
            `CHECK(w, rows[r].exp_cmd)
            w = got2_q.pop_front();
            `CHECK(w, rows[r].exp_cmd)
            `CHECK(dig_lv, rows[r].exp_dig)
            `CHECK(dig_oe, 8'hFF)
            `CHECK({dp_lv, seg_lv}, rows[r].exp_seg)
            `CHECK({dp_oe, seg_oe}, 8'hFF)
            `CHECK(host.echo_r, prev)
            prev = rows[r].word;
            $display("row %0d done", r);
        end
        // A 32-bit frame keeps only its last sixteen bits.
        send_word(16'hDEAD, 1'b0);
        // The gated copy saw no edges, so it still shows the last bit of the third row.
        `CHECK(dout2, 1'b0)
        send_word(16'h0B07, 1'b1);
        wait_words(1);
        repeat (20) @(negedge clk);
        `CHECK(got_q.size(), 1)
        w = got_q.pop_front();
        `CHECK(w, 12'hB07)
        w = got2_q.pop_front();
        `CHECK(w, 12'hB07)
        `CHECK(host.echo_r, 16'hDEAD)
        $display("long frame test done");
        // Stalled bank: nine words are held, the tenth is dropped.
        @(negedge clk);
        rdy = 1'b0;
        for (int i = 0; i < 10; i++) begin
            send_word({12'h030, 4'(i)}, 1'b1);
        end
        repeat (10) @(negedge clk);
        `CHECK(ovr, 1'b1)
        `CHECK(ovr2, 1'b1)
        rdy = 1'b1;
        wait_words(9);
        repeat (20) @(negedge clk);
        `CHECK(got_q.size(), 9)
        for (int i = 0; i < 9; i++) begin
            w = got_q.pop_front();
            `CHECK(w, {8'h30, 4'(i)})
        end
        $display("overrun test done");
        // Reset in mid-run clears the sticky flag.
        srst = 1'b1;
        repeat (5) @(negedge clk);
        check_reset_values();
        srst = 1'b0;
        repeat (3) @(negedge clk);
        // The link starts clean after reset, so the chain echo is all zeros.
        send_word(16'h0A42, 1'b1);
        wait_words(1);
        w = got_q.pop_front();
        `CHECK(w, 12'hA42)
        `CHECK(host.echo_r, 16'h0000)
        $display("mid-run reset test done");
        summarize();
    end
endmodule

bind display_serial_load_port display_serial_load_port_chk #(.SELECT_GATED(SELECT_GATED)) chk (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .serial_clk_in(serial_clk_in),
    .serial_data_in(serial_data_in), .load_in(load_in), .cs_n_in(cs_n_in),
    .serial_data_out(serial_data_out), .serial_data_oe_out(serial_data_oe_out),
    .bank_ready_in(bank_ready_in), .bank_wr_out(bank_wr_out), .bank_addr_out(bank_addr_out),
    .bank_data_out(bank_data_out), .overrun_out(overrun_out), .digit_on_in(digit_on_in),
    .segment_on_in(segment_on_in), .digit_sink_lines_out(digit_sink_lines_out),
    .digit_sink_lines_oe_out(digit_sink_lines_oe_out),
    .segment_source_lines_out(segment_source_lines_out),
    .segment_source_lines_oe_out(segment_source_lines_oe_out),
    .decimal_point_line_out(decimal_point_line_out),
    .decimal_point_line_oe_out(decimal_point_line_oe_out));
